// *** hdl/hcc_defines.svh ***
`ifndef HCC_DEFINES_SVH
`define HCC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define HCC_CONFIG_OFS   12'h000
`define HCC_STATUS_OFS   12'h004
`define HCC_CONFIG_RST   14'h0000

// ----------------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------------
`define HCC_OFF_TIME_LSB   0
`define HCC_OFF_TIME_MSB   3
`define HCC_BLANK_SEL_LSB  4
`define HCC_BLANK_SEL_MSB  5
`define HCC_HYS_START_LSB  6
`define HCC_HYS_START_MSB  8
`define HCC_HYS_END_LSB    9
`define HCC_HYS_END_MSB    12
`define HCC_CHM_BIT        13

// ----------------------------------------------------------------------------
// Timing counts in system clocks, and the hysteresis end bias
// ----------------------------------------------------------------------------
`define HCC_SLOW_BASE    9'd12
`define HCC_SLOW_SHIFT   5
`define HCC_BLANK0       9'd16
`define HCC_BLANK1       9'd24
`define HCC_BLANK2       9'd36
`define HCC_BLANK3       9'd54
`define HCC_DEC_LAST     4'hf
`define HCC_END_BIAS     6'sd3

`endif

// *** hdl/hcc_pkg.sv ***
`default_nettype none
package hcc_pkg;
  // Gray codes along on, slow, fast, slow
  typedef enum logic [2:0] {
    HCC_IDLE  = 3'h0,
    HCC_ON    = 3'h1,
    HCC_SLOW1 = 3'h3,
    HCC_FAST  = 3'h2,
    HCC_SLOW2 = 3'h6
  } hcc_phase_t;
  typedef logic signed [5:0] hcc_hyst_t;
endpackage : hcc_pkg
`default_nettype wire

// *** hdl/hcc_top.sv ***
// Implementation choices: register access over APB and the address map.
`include "hcc_defines.svh"
`default_nettype none
module hcc_top (
  input  wire logic              clk_i,         // System clock, 200 MHz
  input  wire logic              arst_n_i,      // Async reset, active low
  input  wire logic              psel_i,        // APB select
  input  wire logic              penable_i,     // APB enable
  input  wire logic              pwrite_i,      // APB write
  input  wire logic [11:0]       paddr_i,       // APB byte address
  input  wire logic [31:0]       pwdata_i,      // APB write data
  output logic                   pready_o,      // APB ready
  output logic [31:0]            prdata_o,      // APB read data
  output logic                   pslverr_o,     // APB error on unmapped
  input  wire logic [1:0]        cmp_above_i,   // Per coil: current above band
  input  wire logic [1:0]        cmp_below_i,   // Per coil: current below band
  output logic [1:0]             bridge_en_o,   // Per coil: bridge enabled
  output logic [1:0]             drive_on_o,    // Per coil: on phase
  output logic [1:0]             drive_fast_o,  // Per coil: fast decay
  output logic [1:0]             drive_slow_o,  // Per coil: slow decay
  output hcc_pkg::hcc_hyst_t     hyst0_o,       // Coil 0 working hysteresis
  output hcc_pkg::hcc_hyst_t     hyst1_o,       // Coil 1 working hysteresis
  output hcc_pkg::hcc_phase_t    phase0_o,      // Coil 0 phase
  output hcc_pkg::hcc_phase_t    phase1_o       // Coil 1 phase
);
  import hcc_pkg::*;

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  logic [13:0] cfg_reg;
  logic [13:0] cfg_next;
  logic        sel_cfg;
  logic        sel_sts;
  logic [31:0] status;

  assign sel_cfg   = (paddr_i == `HCC_CONFIG_OFS);
  assign sel_sts   = (paddr_i == `HCC_STATUS_OFS);
  assign pready_o  = 1'b1;  // Zero wait states, no stall logic needed
  assign pslverr_o = psel_i & penable_i & ~(sel_cfg | sel_sts);

  // Read mux; unmapped reads return zero
  always_comb begin
    prdata_o = 32'h0000_0000;
    if (psel_i && !pwrite_i && sel_cfg) begin
      prdata_o = {18'h00000, cfg_reg};
    end else if (psel_i && !pwrite_i && sel_sts) begin
      prdata_o = status;
    end
  end

  // Write takes effect in the access cycle only
  always_comb begin
    cfg_next = cfg_reg;
    if (psel_i && penable_i && pwrite_i && sel_cfg) begin
      cfg_next = pwdata_i[13:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_reg <= `HCC_CONFIG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // --------------------------------------------------------------------------
  // Decoded settings shared by both coils
  // --------------------------------------------------------------------------
  logic [3:0] off_time_setting;
  logic [1:0] blank_time_select;
  logic [2:0] hysteresis_start_offset;
  logic [3:0] hysteresis_end_value;
  logic       chop_mode;
  logic       run_ok;
  logic [8:0] slow_load;
  logic [8:0] blank_len;
  hcc_hyst_t  end_eff;
  hcc_hyst_t  start_eff;

  assign off_time_setting        = cfg_reg[`HCC_OFF_TIME_MSB:`HCC_OFF_TIME_LSB];
  assign blank_time_select       = cfg_reg[`HCC_BLANK_SEL_MSB:`HCC_BLANK_SEL_LSB];
  assign hysteresis_start_offset = cfg_reg[`HCC_HYS_START_MSB:`HCC_HYS_START_LSB];
  assign hysteresis_end_value    = cfg_reg[`HCC_HYS_END_MSB:`HCC_HYS_END_LSB];
  assign chop_mode               = cfg_reg[`HCC_CHM_BIT];
  // Constant off-time mode is not built, so that mode parks the bridge
  assign run_ok    = (off_time_setting != 4'h0) && !chop_mode;
  assign slow_load = `HCC_SLOW_BASE
                     + ({5'h00, off_time_setting} << `HCC_SLOW_SHIFT) - 9'd1;
  assign end_eff   = $signed({2'b00, hysteresis_end_value}) - `HCC_END_BIAS;
  assign start_eff = end_eff + $signed({3'b000, hysteresis_start_offset})
                     + 6'sd1;

  // Blank table
  always_comb begin
    unique case (blank_time_select)
      2'd0: blank_len = `HCC_BLANK0;
      2'd1: blank_len = `HCC_BLANK1;
      2'd2: blank_len = `HCC_BLANK2;
      2'd3: blank_len = `HCC_BLANK3;
    endcase
  end

  // --------------------------------------------------------------------------
  // Comparator synchronisers, three stages, change on stage 2/3 agreement
  // --------------------------------------------------------------------------
  logic [3:0] cmp_s1_reg;
  logic [3:0] cmp_s2_reg;
  logic [3:0] cmp_s3_reg;
  logic [3:0] cmp_reg;
  logic [3:0] cmp_next;

  always_comb begin
    cmp_next = cmp_reg;
    for (int b = 0; b < 4; b++) begin
      if (cmp_s2_reg[b] == cmp_s3_reg[b]) begin
        cmp_next[b] = cmp_s3_reg[b];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmp_s1_reg <= 4'h0;
      cmp_s2_reg <= 4'h0;
      cmp_s3_reg <= 4'h0;
      cmp_reg    <= 4'h0;
    end else begin
      cmp_s1_reg <= {cmp_below_i, cmp_above_i};
      cmp_s2_reg <= cmp_s1_reg;
      cmp_s3_reg <= cmp_s2_reg;
      cmp_reg    <= cmp_next;
    end
  end

  // --------------------------------------------------------------------------
  // Per-coil chopper
  // --------------------------------------------------------------------------
  hcc_phase_t st_reg   [2];
  hcc_hyst_t  hyst_reg [2];

  // Each coil is a private copy with no shared state
  for (genvar c = 0; c < 2; c++) begin : g_coil
    hcc_phase_t st_next;
    logic [8:0] tmr_reg;
    logic [8:0] tmr_next;
    logic [3:0] div_reg;
    logic [3:0] div_next;
    hcc_hyst_t  hy_next;
    logic [8:0] len_reg;
    logic       above;
    logic       below;

    assign above = cmp_reg[c];
    assign below = cmp_reg[c+2];

    // Phase sequencer with one down timer for blank and off time
    always_comb begin
      st_next  = st_reg[c];
      tmr_next = (tmr_reg != 9'd0) ? tmr_reg - 9'd1 : 9'd0;
      unique case (st_reg[c])
        HCC_IDLE: begin
          if (run_ok) begin
            st_next  = HCC_ON;
            tmr_next = blank_len - 9'd1;
          end
        end
        HCC_ON: begin
          if (tmr_reg == 9'd0 && above) begin
            st_next  = HCC_SLOW1;
            tmr_next = slow_load;
          end
        end
        HCC_SLOW1: begin
          if (tmr_reg == 9'd0) begin
            st_next  = HCC_FAST;
            tmr_next = blank_len - 9'd1;
          end
        end
        HCC_FAST: begin
          if (tmr_reg == 9'd0 && below) begin
            st_next  = HCC_SLOW2;
            tmr_next = slow_load;
          end
        end
        HCC_SLOW2: begin
          if (tmr_reg == 9'd0) begin
            st_next  = HCC_ON;
            tmr_next = blank_len - 9'd1;
          end
        end
        default: begin
          st_next = HCC_IDLE;
        end
      endcase
      if (!run_ok) begin
        st_next  = HCC_IDLE;
        tmr_next = 9'd0;
      end
    end

    // Decrementer restarts with each cycle so steps align to the cycle start
    always_comb begin
      div_next = div_reg + 4'h1;
      hy_next  = hyst_reg[c];
      if (st_next == HCC_ON && st_reg[c] != HCC_ON) begin
        div_next = 4'h0;
        hy_next  = start_eff;
      end else if (st_reg[c] == HCC_IDLE) begin
        div_next = 4'h0;
      end else if (div_reg == `HCC_DEC_LAST && hyst_reg[c] > end_eff) begin
        hy_next  = hyst_reg[c] - 6'sd1;
      end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        st_reg[c]   <= HCC_IDLE;
        tmr_reg     <= 9'd0;
        div_reg     <= 4'h0;
        hyst_reg[c] <= 6'sd0;
      end else begin
        st_reg[c]   <= st_next;
        tmr_reg     <= tmr_next;
        div_reg     <= div_next;
        hyst_reg[c] <= hy_next;
      end
    end

    // Phase outputs decoded from the state flops
    assign bridge_en_o[c]  = (st_reg[c] != HCC_IDLE);
    assign drive_on_o[c]   = (st_reg[c] == HCC_ON);
    assign drive_fast_o[c] = (st_reg[c] == HCC_FAST);
    assign drive_slow_o[c] = (st_reg[c] == HCC_SLOW1) || (st_reg[c] == HCC_SLOW2);

    // Checker helper: clocks spent in the current phase
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        len_reg <= 9'd0;
      end else begin
        len_reg <= (st_next != st_reg[c]) ? 9'd0 : len_reg + 9'd1;
      end
    end

    sequence s_cycle_start;
      st_reg[c] != HCC_ON && st_next == HCC_ON;
    endsequence

    a_phase_order: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_reg[c] == HCC_ON && st_next != HCC_ON && run_ok) |-> st_next == HCC_SLOW1)
      else $error("on phase not followed by slow decay");
    a_fast_next: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (st_reg[c] == HCC_FAST && st_next != HCC_FAST && run_ok) |-> st_next == HCC_SLOW2)
      else $error("fast decay not followed by second slow decay");
    a_slow_len: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (drive_slow_o[c] && st_next != st_reg[c] && run_ok && $stable(cfg_reg))
      |-> len_reg == slow_load)
      else $error("slow decay length wrong");
    a_blank_min: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      ((drive_on_o[c] || drive_fast_o[c]) && st_next != st_reg[c] && run_ok)
      |-> len_reg >= blank_len - 9'd1)
      else $error("phase ended inside blank time");
    a_on_cause: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (drive_on_o[c] && st_next == HCC_SLOW1) |-> above)
      else $error("on phase ended without comparator");
    a_fast_cause: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (drive_fast_o[c] && st_next == HCC_SLOW2) |-> below)
      else $error("fast decay ended without comparator");
    a_hyst_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_cycle_start ##1 1'b1 |-> hyst_reg[c] == $past(start_eff))
      else $error("hysteresis not loaded at cycle start");
    a_start_ofs: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_cycle_start ##1 $stable(cfg_reg)
      |-> hyst_reg[c] - end_eff == $signed({3'b000, hysteresis_start_offset}) + 6'sd1)
      else $error("start offset is not setting plus one");
    a_hyst_step: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (drive_slow_o[c] && st_next == st_reg[c] && div_reg != `HCC_DEC_LAST)
      ##1 1'b1 |-> $stable(hyst_reg[c]))
      else $error("hysteresis moved off the 16 clock step");
    a_hyst_floor: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (bridge_en_o[c] && $stable(cfg_reg) && $past(bridge_en_o[c]))
      |-> hyst_reg[c] >= $signed({2'b00, hysteresis_end_value}) - 6'sd3)
      else $error("hysteresis below end value");
    a_off_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !run_ok |=> !bridge_en_o[c] && !drive_on_o[c] && !drive_fast_o[c])
      else $error("drivers active while disabled");
  end

  assign hyst0_o  = hyst_reg[0];
  assign hyst1_o  = hyst_reg[1];
  assign phase0_o = st_reg[0];
  assign phase1_o = st_reg[1];
  assign status   = {10'h000, hyst_reg[1], 2'b00, hyst_reg[0],
                     1'b0, st_reg[1], 1'b0, st_reg[0]};
endmodule : hcc_top
`default_nettype wire

// *** testbench/hcc_coil_model.sv ***
`default_nettype none
module hcc_coil_model (
  input  wire logic       clk_i,     // System clock
  input  wire logic       arst_n_i,  // Async reset, active low
  input  wire logic       on_i,      // Bridge in on phase
  input  wire logic       fast_i,    // Bridge in fast decay
  input  wire logic [7:0] dly_i,     // Clocks until the band is crossed
  output logic            above_o,   // Current above band
  output logic            below_o    // Current below band
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // Coil current
  // --------------------------------------------------------------
  logic [7:0] cnt_reg;  // Clocks spent ramping in this phase
  // Current ramps while driven or fast decaying and rests in slow decay;
  // the comparator output is raw, so it may already be set during blanking
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg <= 8'h00;
      above_o <= 1'b0;
      below_o <= 1'b0;
    end else begin
      if (!(on_i || fast_i)) begin
        cnt_reg <= 8'h00;
      end else if (cnt_reg != 8'hff) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
      above_o <= on_i && (cnt_reg >= dly_i);    // Saturates: held until phase ends
      below_o <= fast_i && (cnt_reg >= dly_i);
    end
  end
endmodule : hcc_coil_model
`default_nettype wire

// *** testbench/tb_top.sv ***
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hcc_pkg::*;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, cfg_w;
  logic pready, pslverr, err;
  logic [1:0] above, below, bridge_en, drv_on, drv_fast, drv_slow;
  hcc_hyst_t  hy [2];
  hcc_phase_t ph [2];
  hcc_phase_t ph_q [2];
  hcc_hyst_t  hy_q [2];
  int len [2], hgap [2], dly [2];
  int cycles, lo, exp_slow, exp_blank, exp_hs, exp_he, mismatches, checks_done;
  int tof [5] = '{2, 1, 1, 3, 15};
  int bsel [5] = '{0, 1, 2, 3, 0};
  int hst [5] = '{6, 0, 3, 7, 0};
  int hen [5] = '{0, 6, 13, 3, 0};
  int sdl [5] = '{60, 1, 30, 5, 90};
  int blk [4] = '{16, 24, 36, 54};
  always #2.5 clk = ~clk;
  // --------------------------------------------------------------
  // Design and coil models
  // --------------------------------------------------------------
  hcc_top dut_u (.clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .cmp_above_i(above), .cmp_below_i(below),
    .bridge_en_o(bridge_en), .drive_on_o(drv_on), .drive_fast_o(drv_fast),
    .drive_slow_o(drv_slow), .hyst0_o(hy[0]), .hyst1_o(hy[1]), .phase0_o(ph[0]),
    .phase1_o(ph[1]));
  for (genvar g = 0; g < 2; g++) begin : g_coil
    hcc_coil_model m_u (.clk_i(clk), .arst_n_i(arst_n), .on_i(drv_on[g]),
      .fast_i(drv_fast[g]), .dly_i(dly[g][7:0]), .above_o(above[g]), .below_o(below[g]));
  end
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic final_report();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  function automatic hcc_phase_t nxt(hcc_phase_t p);
    case (p)
      HCC_ON:    return HCC_SLOW1;
      HCC_SLOW1: return HCC_FAST;
      HCC_FAST:  return HCC_SLOW2;
      default:   return HCC_ON;
    endcase
  endfunction : nxt
  // --------------------------------------------------------------
  // Phase monitor
  // --------------------------------------------------------------
  // Judges order, lengths and hysteresis steps of both coils every clock;
  // leaving or entering idle is skipped since config writes cut phases short
  always @(posedge clk) begin
    // Outputs are unknown until the first edge inside reset, so judge only once out of it
    for (int c = 0; c < 2 && arst_n === 1'b1; c++) begin
      chk(bridge_en[c], ph[c] !== HCC_IDLE);
      chk(drv_on[c], ph[c] === HCC_ON);
      chk(drv_fast[c], ph[c] === HCC_FAST);
      chk(drv_slow[c], ph[c] === HCC_SLOW1 || ph[c] === HCC_SLOW2);
      lo = (exp_blank > dly[c] + 4) ? exp_blank : dly[c] + 4;
      if (ph[c] !== ph_q[c] && ph[c] !== HCC_IDLE && ph_q[c] !== HCC_IDLE) begin
        chk(ph[c], nxt(ph_q[c]));
        if (ph_q[c] === HCC_SLOW1 || ph_q[c] === HCC_SLOW2) begin
          chk(len[c], exp_slow);
        end else begin
          chk(len[c] >= exp_blank && len[c] <= lo + 4, 1'b1);
        end
      end
      if (ph[c] === HCC_ON && ph_q[c] !== HCC_ON) begin
        chk(hy[c], exp_hs);
        hgap[c] = 1;
        cycles += (c == 0);
      end else if (hy[c] !== hy_q[c] && ph[c] !== HCC_IDLE && ph_q[c] !== HCC_IDLE) begin
        chk(hgap[c], 16);
        chk(hy[c], hy_q[c] - 6'sd1);
        chk(hy[c] >= exp_he, 1'b1);
        hgap[c] = 1;
      end else begin
        hgap[c]++;
      end
      len[c] = (ph[c] !== ph_q[c]) ? 1 : len[c] + 1;
      ph_q[c] = ph[c];
      hy_q[c] = hy[c];
    end
  end
  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    dly = '{1, 1};
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0);
    chk(err, 1'b0);
    // Status after reset: both coils idle, hysteresis cleared
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 12'hffc, 32'h1);
    chk(err, 1'b1);
    // Each entry runs four full coil 0 chopper cycles under its own setup
    for (int i = 0; i < 5; i++) begin
      exp_slow = 12 + 32 * tof[i];
      exp_blank = blk[bsel[i]];
      exp_hs = (hst[i] + 1) + (hen[i] - 3);
      exp_he = hen[i] - 3;
      dly[1] <= sdl[i];
      // Start plus end settings stay at or below sixteen in every entry
      cfg_w = {18'h0, 1'b0, 4'(hen[i]), 3'(hst[i]), 2'(bsel[i]), 4'(tof[i])};
      apb(1'b1, 12'h000, cfg_w);
      apb(1'b0, 12'h000, 32'h0);
      chk(q, cfg_w);
      cycles = 0;
      while (cycles < 4) @(posedge clk);
      apb(1'b1, 12'h000, 32'h0);
      repeat (2) @(posedge clk);
      chk(ph[0], HCC_IDLE);
    end
    apb(1'b1, 12'h000, 32'h0000_2001);
    repeat (4) @(posedge clk);
    chk({ph[1], ph[0], bridge_en}, {HCC_IDLE, HCC_IDLE, 2'b00});
    final_report();
  end
  // Cuts a hang short well after the longest setup's cycles
  initial begin
    #300000;
    mismatches++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
